// ### dbac_regs.vh
`ifndef DBAC_REGS_VH
`define DBAC_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DBAC_OFF_SRC_END 12'h000
`define DBAC_OFF_DST_END 12'h004
`define DBAC_OFF_CTRL 12'h008
`define DBAC_OFF_BEATS 12'h00c
`define DBAC_OFF_CMD 12'h010
`define DBAC_OFF_STATUS 12'h014
`define DBAC_OFF_SRC_CUR 12'h018
`define DBAC_OFF_DST_CUR 12'h01c
// ----------------------------------------
// Control fields
// ----------------------------------------
`define DBAC_CTRL_SOURCE_INCREMENT_ON_BIT 0
`define DBAC_CTRL_DESTINATION_INCREMENT_ON_BIT 1
`define DBAC_CTRL_STEP_SIDE_SELECT_BIT 2
`define DBAC_CTRL_WIDTH_LSB 3
`define DBAC_CTRL_WIDTH_MSB 4
`define DBAC_CTRL_STEP_LSB 5
`define DBAC_CTRL_STEP_MSB 7
`define DBAC_CMD_START_BIT 0
`define DBAC_CMD_BEAT_BIT 1
`define DBAC_STAT_BUSY_BIT 0
`define DBAC_STAT_DONE_BIT 1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DBAC_RST_WORD 32'h00000000
`define DBAC_RST_CTRL 8'h00
`define DBAC_RST_BEATS 16'h0000
`endif

// ### dbac_calc.v
`timescale 1ns/1ps
`include "dbac_regs.vh"

// Operation
// RQ1: The source end word is a full 32-bit field read and written by software.
// RQ2: With source increment off every source beat uses the stored source word.
// RQ3: With source increment on the offset is beats times bytes, scaled by two to the step when step select is one.
// RQ4: The destination end word is a full 32-bit field read and written by software.
// RQ5: With destination increment off every destination beat uses the stored destination word.
// RQ6: With destination increment on the offset is beats times bytes, scaled by two to the step when step select is zero.
// RQ7: The beat count in the offset is the programmed initial count, never the running count.
// RQ8: Bytes per beat are the width code plus one.
// RQ9: The step field scales the stride by a power of two on the side step select names.
// RQ10: Each side starts at its first-beat address and successive beats advance from it.
// RQ11: The first-beat address is the stored end value minus the offset, then it advances one stride per beat.
module dbac_calc (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire [31:0] src_beat_addr,
  output wire [31:0] dst_beat_addr,
  output wire busy
);

  // ----------------------------------------
  // Walk states
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_WALK = 1'b1;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] src_end_q;
  reg [31:0] src_end_d;
  reg [31:0] dst_end_q;
  reg [31:0] dst_end_d;
  reg [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  reg [15:0] beats_q;
  reg [15:0] beats_d;
  reg [15:0] left_q;
  reg [15:0] left_d;
  reg done_q;
  reg done_d;
  reg state_q;
  reg state_d;
  reg [31:0] src_cur_q;
  reg [31:0] src_cur_d;
  reg [31:0] dst_cur_q;
  reg [31:0] dst_cur_d;
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg [31:0] rdata;
  reg hit;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire access;
  wire setup_rd;
  wire wr_en;
  wire idle;
  wire sel_src_end;
  wire sel_dst_end;
  wire sel_ctrl;
  wire sel_beats;
  wire sel_cmd;

  assign access = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_en = access & pwrite;
  assign idle = (state_q == ST_IDLE);
  assign sel_src_end = (paddr == `DBAC_OFF_SRC_END);
  assign sel_dst_end = (paddr == `DBAC_OFF_DST_END);
  assign sel_ctrl = (paddr == `DBAC_OFF_CTRL);
  assign sel_beats = (paddr == `DBAC_OFF_BEATS);
  assign sel_cmd = (paddr == `DBAC_OFF_CMD);

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  wire src_inc;
  wire dst_inc;
  wire step_sel;
  wire [1:0] width_code;
  wire [2:0] step_exp;

  assign src_inc = ctrl_q[`DBAC_CTRL_SOURCE_INCREMENT_ON_BIT];
  assign dst_inc = ctrl_q[`DBAC_CTRL_DESTINATION_INCREMENT_ON_BIT];
  assign step_sel = ctrl_q[`DBAC_CTRL_STEP_SIDE_SELECT_BIT];
  assign width_code = ctrl_q[`DBAC_CTRL_WIDTH_MSB:`DBAC_CTRL_WIDTH_LSB];
  assign step_exp = ctrl_q[`DBAC_CTRL_STEP_MSB:`DBAC_CTRL_STEP_LSB];

  // ----------------------------------------
  // Stride and offset
  // ----------------------------------------
  wire [2:0] bytes_per_beat;
  wire [31:0] base_stride;
  wire [31:0] scaled_stride;
  wire [31:0] src_stride;
  wire [31:0] dst_stride;
  wire [31:0] beats_w;
  wire [63:0] src_prod;
  wire [63:0] dst_prod;
  wire [31:0] src_off;
  wire [31:0] dst_off;
  wire [31:0] src_first;
  wire [31:0] dst_first;
  wire start_wr;
  wire beat_wr;
  wire last_beat;

  // RQ8: bytes per beat
  assign bytes_per_beat = {1'b0, width_code} + 3'h1;
  assign base_stride = {29'h0, bytes_per_beat};
  // RQ9: power-of-two step
  assign scaled_stride = base_stride << step_exp;
  // RQ3: source scaled when one
  assign src_stride = step_sel ? scaled_stride : base_stride;
  // RQ6: destination scaled when zero
  assign dst_stride = step_sel ? base_stride : scaled_stride;
  // RQ7: initial programmed count
  assign beats_w = {16'h0000, beats_q};
  assign src_prod = beats_w * src_stride;
  assign dst_prod = beats_w * dst_stride;
  assign src_off = src_prod[31:0];
  assign dst_off = dst_prod[31:0];
  // RQ2: fixed source address
  // RQ11: recover source first beat
  assign src_first = src_inc ? (src_end_q - src_off) : src_end_q;
  // RQ5: fixed destination address
  // RQ11: recover destination first beat
  assign dst_first = dst_inc ? (dst_end_q - dst_off) : dst_end_q;
  assign start_wr = wr_en & sel_cmd & pwdata[`DBAC_CMD_START_BIT];
  assign beat_wr = wr_en & sel_cmd & pwdata[`DBAC_CMD_BEAT_BIT];
  assign last_beat = (left_q == 16'h0001);

  // ----------------------------------------
  // Descriptor next value
  // ----------------------------------------
  always @*
  begin
    src_end_d = src_end_q;
    dst_end_d = dst_end_q;
    ctrl_d = ctrl_q;
    beats_d = beats_q;
    if (wr_en && idle)
    begin
      // RQ1: source word write
      if (sel_src_end)
      begin
        src_end_d = pwdata;
      end
      // RQ4: destination word write
      if (sel_dst_end)
      begin
        dst_end_d = pwdata;
      end
      if (sel_ctrl)
      begin
        ctrl_d = pwdata[7:0];
      end
      if (sel_beats)
      begin
        beats_d = pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Descriptor storage
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_end_q <= `DBAC_RST_WORD;
      dst_end_q <= `DBAC_RST_WORD;
      ctrl_q <= `DBAC_RST_CTRL;
      beats_q <= `DBAC_RST_BEATS;
    end
    else
    begin
      src_end_q <= src_end_d;
      dst_end_q <= dst_end_d;
      ctrl_q <= ctrl_d;
      beats_q <= beats_d;
    end
  end

  // ----------------------------------------
  // Beat walk next value
  // ----------------------------------------
  always @*
  begin
    state_d = state_q;
    left_d = left_q;
    done_d = done_q;
    src_cur_d = src_cur_q;
    dst_cur_d = dst_cur_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_wr)
        begin
          src_cur_d = src_first;
          dst_cur_d = dst_first;
          left_d = beats_q;
          done_d = (beats_q == 16'h0000);
          if (beats_q != 16'h0000)
          begin
            state_d = ST_WALK;
          end
        end
      end
      ST_WALK:
      begin
        if (beat_wr)
        begin
          // RQ10: advance from first beat
          if (src_inc)
          begin
            src_cur_d = src_cur_q + src_stride;
          end
          if (dst_inc)
          begin
            dst_cur_d = dst_cur_q + dst_stride;
          end
          left_d = left_q - 16'h0001;
          if (last_beat)
          begin
            state_d = ST_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Beat walk storage
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      left_q <= `DBAC_RST_BEATS;
      done_q <= 1'b0;
      src_cur_q <= `DBAC_RST_WORD;
      dst_cur_q <= `DBAC_RST_WORD;
    end
    else
    begin
      state_q <= state_d;
      left_q <= left_d;
      done_q <= done_d;
      src_cur_q <= src_cur_d;
      dst_cur_q <= dst_cur_d;
    end
  end

  // ----------------------------------------
  // APB read mux
  // ----------------------------------------
  always @*
  begin
    rdata = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `DBAC_OFF_SRC_END: rdata = src_end_q;
      `DBAC_OFF_DST_END: rdata = dst_end_q;
      `DBAC_OFF_CTRL: rdata = {24'h000000, ctrl_q};
      `DBAC_OFF_BEATS: rdata = {16'h0000, beats_q};
      `DBAC_OFF_CMD: rdata = 32'h00000000;
      `DBAC_OFF_STATUS: rdata = {left_q, 14'h0000, done_q, busy};
      `DBAC_OFF_SRC_CUR: rdata = src_cur_q;
      `DBAC_OFF_DST_CUR: rdata = dst_cur_q;
      default:
      begin
        rdata = 32'h00000000;
        hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  always @*
  begin
    prdata_d = 32'h00000000;
    if (setup_rd)
    begin
      prdata_d = rdata;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= `DBAC_RST_WORD;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign src_beat_addr = src_cur_q;
  assign dst_beat_addr = dst_cur_q;
  assign busy = (state_q == ST_WALK);

endmodule

// ### dbac_desc.sv
`timescale 1ns/1ps
module dbac_desc(
input wire [7:0] ctrl,
input wire [15:0] beats,
input wire [31:0] s0, d0,
output wire [31:0] se, de);
wire [31:0] b = {30'h0, ctrl[4:3]} + 32'h1;
assign se = ctrl[0] ? s0 + beats * (ctrl[2] ? b << ctrl[7:5] : b) : s0;
assign de = ctrl[1] ? d0 + beats * (ctrl[2] ? b : b << ctrl[7:5]) : d0;
endmodule

// ### dbac_chk.sv
`timescale 1ns/1ps
module dbac_chk(
input wire pclk, presetn, psel, penable, pwrite, pready, pslverr, busy,
input wire [11:0] paddr,
input wire [31:0] pwdata, prdata, src_beat_addr, dst_beat_addr);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
reg [7:0] c_q;
wire w = psel && penable && pwrite;
wire r = psel && penable && !pwrite;
wire cmd = w && paddr == 12'h010;
wire bt = cmd && pwdata[1] && busy;
wire [31:0] b = {30'h0, c_q[4:3]} + 32'h1;
wire [31:0] ss = c_q[0] ? b << (c_q[2] ? c_q[7:5] : 3'h0) : 32'h0;
wire [31:0] ds = c_q[1] ? b << (c_q[2] ? 3'h0 : c_q[7:5]) : 32'h0;
always @(posedge pclk or negedge presetn)
  if (!presetn) c_q <= 8'h00;
  else if (w && paddr == 12'h008 && !busy) c_q <= pwdata[7:0];
a_ready_high: assert property (pready) else $error("bad ready");
a_bad_addr: assert property (psel && paddr > 12'h01c |-> pslverr == penable)
  else $error("bad error");
a_src_step: assert property (bt |=> src_beat_addr == $past(src_beat_addr) + ss)
  else $error("bad src step");
a_dst_step: assert property (bt |=> dst_beat_addr == $past(dst_beat_addr) + ds)
  else $error("bad dst step");
a_idle_hold: assert property (
  !busy && !cmd |=> $stable(src_beat_addr) && $stable(dst_beat_addr)) else $error("bad idle");
a_busy_hold: assert property (busy && !bt |=> busy && $stable(src_beat_addr))
  else $error("bad hold");
a_src_read: assert property (r && paddr == 12'h018 |-> prdata == src_beat_addr)
  else $error("bad src read");
a_dst_read: assert property (r && paddr == 12'h01c |-> prdata == dst_beat_addr)
  else $error("bad dst read");
cover property (bt);
cover property ($fell(busy));
cover property (pslverr);
endmodule
bind dbac_calc dbac_chk u_chk(.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
  .busy, .paddr, .pwdata, .prdata, .src_beat_addr, .dst_beat_addr);

// ### tb.sv
`timescale 1ns/1ps
module tb;
reg pclk, presetn, psel, penable, pwrite, er;
reg [11:0] paddr;
reg [7:0] ct;
reg [15:0] bt;
reg [31:0] pwdata, rd, s0, d0;
wire [31:0] prdata, src_beat_addr, dst_beat_addr, se, de;
wire pready, pslverr, busy;
int err_count, total_checks, i, k;
dbac_calc DUT(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .src_beat_addr, .dst_beat_addr, .busy);
dbac_desc u_desc(.ctrl(ct), .beats(bt), .s0, .d0, .se, .de);
function [31:0] st(input d);
  st = ({30'h0, ct[4:3]} + 32'h1) << ((ct[2] ^ d) ? ct[7:5] : 3'h0);
endfunction
task ck(string n, logic [31:0] s, e);
  total_checks++;
  if (s !== e) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end
endtask
task bus(input w, input [11:0] a, input [31:0] d);
  @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
  @(posedge pclk) penable <= 1;
  do @(posedge pclk); while (pready !== 1'b1);
  {rd, er} = {prdata, pslverr};
  {psel, penable} <= 2'b00;
  @(negedge pclk);
endtask
task close_out;
  if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
  else $display("Run complete: FAIL");
  $finish;
endtask
initial begin pclk = 0; forever #12.5 pclk = ~pclk; end
initial begin #500000 err_count++; close_out; end
initial
begin
  {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
  i = $urandom(32'h37b6);
  repeat (16) @(posedge pclk);
  presetn <= 1;
  for (i = 0; i < 9; i++)
  begin
    bus(0, 12'(4 * i), 0);
    ck("reset_read", rd, 0);
    ck("slverr", er, i == 8);
  end
  for (i = 0; i < 12; i++)
  begin
    ct = $urandom; s0 = $urandom; d0 = $urandom;
    ct[2:0] = i[2:0];
    bt = i < 2 ? i : $urandom_range(1, 5);
    bus(1, 12'h008, ct); bus(1, 12'h00c, bt); bus(1, 0, se); bus(1, 4, de);
    bus(1, 12'h010, 1);
    ck("busy", busy, bt != 0);
    bus(1, 0, ~se);
    for (k = 0; k < bt; k++)
    begin
      ck("src", src_beat_addr, ct[0] ? s0 + k * st(0) : s0);
      ck("dst", dst_beat_addr, ct[1] ? d0 + k * st(1) : d0);
      bus(1, 12'h010, 2);
    end
    ck("idle", busy, 0);
    bus(0, 12'h014, 0);
    ck("status", rd, 32'h2);
    bus(0, 0, 0);
    ck("src_end", rd, bt ? se : ~se);
  end
  close_out;
end
endmodule
